// [cfm_pkg.sv]
// Constants, register map and types for the chip fault monitor.
// Functional notes
// - On logic supply rising past lockout, reset all registers and fault states.
// - After power-on reset, set any_fault_flag and power_up_reset_flag.
// - During power-up, hold gate drive off and logic inactive until supply good.
// - Logic supply loss disables outputs at once; power-up repeats on recovery.
// - Logic supply lockout cannot be masked by any mask bit.
// - Overtemperature sets overheat_fault_flag; with shutdown enabled, gates go off.
// - With fault_shutdown_enable clear, overtemperature only sets the flag.
// - Overtemperature recovery re-enables outputs; overheat_fault_flag stays latched.
// - Bad edge count or even parity cancels transfer and sets serial_error_flag.
// - A rejected write transfer does not reset the status register.
// - A rejected diagnostic read does not clear the addressed register.
// - Regulator undervoltage sets regulator_low_flag and forces all gates low.
// - Regulator recovery re-enables gates; regulator_low_flag stays latched.
// - Regulator undervoltage monitor is active during power-up, gates low.
// - Mask bit disables regulator undervoltage monitor; software should avoid it.
// - Regulator overvoltage only sets regulator_high_flag, which stays latched.
// - Heat warning only sets heat_warning_flag, which stays latched.
// - any_fault_flag is status bit 15, high when any status fault is set.
// - Diagnostic bits latch on detection and clear only on fault reset.
// - All diagnostics maskable except power-on reset, serial error, overtemperature.
// - Status register contents shift out on serial data during every transfer.
package cfm_pkg;
	// Avalon register byte offsets.
	localparam logic [3:0] CFM_ADDR_STATUS = 4'h0;
	localparam logic [3:0] CFM_ADDR_DIAG1 = 4'h4;
	localparam logic [3:0] CFM_ADDR_CONFIG = 4'h8;
	localparam logic [3:0] CFM_ADDR_CLEAR = 4'hC;
	// Status bit positions.
	localparam int CFM_ST_ANY = 15;
	localparam int CFM_ST_POR = 14;
	localparam int CFM_ST_OT = 13;
	localparam int CFM_ST_TW = 12;
	localparam int CFM_ST_SE = 11;
	// Diagnostic word one bit positions.
	localparam int CFM_D1_RLOW = 0;
	localparam int CFM_D1_RHIGH = 1;
	// Config bit positions and reset value.
	localparam int CFM_CF_ESF = 0;
	localparam int CFM_CF_MRLOW = 1;
	localparam int CFM_CF_MRHIGH = 2;
	localparam int CFM_CF_MTW = 3;
	localparam logic [3:0] CFM_CONFIG_RST = 4'h1;
	// Clear register bit positions.
	localparam int CFM_CL_STATUS = 0;
	localparam int CFM_CL_DIAG1 = 1;
	// Serial frame layout.
	localparam logic [4:0] CFM_FRAME_BITS = 5'h10;
	localparam int CFM_FR_WRITE = 10;
	localparam logic [4:0] CFM_SER_DIAG1 = 5'h01;
	// Synchronised comparator levels, high means the condition is present.
	typedef struct packed {
		logic logic_ok;
		logic overtemp;
		logic heat_warn;
		logic reg_low;
		logic reg_high;
	} cfm_mon_t;
endpackage : cfm_pkg

// [cfm_top.sv]
// Chip-level fault supervisor with Avalon-MM registers and serial frame checker.
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
module cfm_top import cfm_pkg::*; (
	// Clock, reset and enable.
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic ce_i,
	// Analog comparator levels, asynchronous.
	input wire logic logic_ok_i,
	input wire logic overtemp_i,
	input wire logic heat_warn_i,
	input wire logic reg_low_i,
	input wire logic reg_high_i,
	// Serial interface pins, asynchronous.
	input wire logic serial_clk_i,
	input wire logic frame_strobe_n_i,
	input wire logic serial_din_i,
	output logic serial_dout_o,
	// Gate drive permission.
	output logic gate_enable_o,
	// Avalon-MM slave.
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o
);
	cfm_mon_t mon_meta;
	cfm_mon_t mon;
	logic [2:0] ser_meta;
	logic [2:0] ser_sync;
	logic sclk_prev;
	logic strb_prev;
	logic logic_up;
	logic por_pending;
	logic ot_live;
	logic rlow_live;
	logic [15:0] status;
	logic [1:0] diag1;
	logic [3:0] config_q;
	logic [15:0] shift_in;
	logic [15:0] shift_out;
	logic [4:0] edge_cnt;
	logic in_frame;
	logic req_pending;
	logic bus_wr;
	logic sclk_rise;
	logic frame_start;
	logic frame_end;
	logic frame_good;
	logic frame_bad;
	logic ser_status_reset;
	logic ser_diag1_reset;
	logic sw_status_clear;
	logic sw_diag1_clear;
	logic [4:0] status_set;
	logic [1:0] diag1_set;

	// Odd parity over a whole frame, used only for the incoming shift word.
	function automatic logic cfm_odd(input logic [15:0] w);
		cfm_odd = ^w;
	endfunction : cfm_odd

	// Two flops on every comparator and serial input pin; the first stage feeds only the second.
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			mon_meta <= '0;
			mon <= '0;
			ser_meta <= 3'h2;
			ser_sync <= 3'h2;
		end else if (ce_i) begin
			mon_meta <= {logic_ok_i, overtemp_i, heat_warn_i, reg_low_i, reg_high_i};
			mon <= mon_meta;
			ser_meta <= {serial_clk_i, frame_strobe_n_i, serial_din_i};
			ser_sync <= ser_meta;
		end
	end

	// Edge detection on synchronised serial pins.
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			sclk_prev <= 1'b0;
			strb_prev <= 1'b1;
		end else if (ce_i) begin
			sclk_prev <= ser_sync[2];
			strb_prev <= ser_sync[1];
		end
	end

	assign sclk_rise = ser_sync[2] & ~sclk_prev & ~ser_sync[1];
	assign frame_start = strb_prev & ~ser_sync[1];
	assign frame_end = ~strb_prev & ser_sync[1] & in_frame;
	// A frame is good only with exactly sixteen edges and odd parity.
	assign frame_good = frame_end && (edge_cnt == CFM_FRAME_BITS) && cfm_odd(shift_in);
	assign frame_bad = frame_end && !frame_good;
	// Effects of a transfer happen only when the frame is good.
	assign ser_status_reset = frame_good & shift_in[CFM_FR_WRITE];
	assign ser_diag1_reset = frame_good & ~shift_in[CFM_FR_WRITE]
		& (shift_in[15:11] == CFM_SER_DIAG1);
	assign bus_wr = avs_write_i & ~avs_waitrequest_o;
	assign sw_status_clear = bus_wr && (avs_address_i == CFM_ADDR_CLEAR)
		&& avs_writedata_i[CFM_CL_STATUS];
	assign sw_diag1_clear = bus_wr && (avs_address_i == CFM_ADDR_CLEAR)
		&& avs_writedata_i[CFM_CL_DIAG1];

	// Logic supply lockout: no mask reaches this path, and loss wipes flags, live states, shifter and config.
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			logic_up <= 1'b0;
			por_pending <= 1'b0;
		end else if (ce_i) begin
			logic_up <= mon.logic_ok;
			por_pending <= mon.logic_ok & ~logic_up;
		end
	end

	// Live fault states, separate from the latched flags so outputs recover.
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || !logic_up) begin
			ot_live <= 1'b0;
			rlow_live <= 1'b1;
		end else if (ce_i) begin
			ot_live <= mon.overtemp;
			rlow_live <= mon.reg_low & ~config_q[CFM_CF_MRLOW];
		end
	end

	// Flag set terms; power-on, serial error and overtemperature are unmaskable.
	assign status_set[0] = por_pending;
	assign status_set[1] = mon.overtemp;
	assign status_set[2] = mon.heat_warn & ~config_q[CFM_CF_MTW];
	assign status_set[3] = frame_bad;
	assign status_set[4] = |status_set[3:0];
	assign diag1_set[0] = mon.reg_low & ~config_q[CFM_CF_MRLOW];
	assign diag1_set[1] = mon.reg_high & ~config_q[CFM_CF_MRHIGH];

	// Status flags latch; a set in the same cycle as a clear wins.
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || !logic_up) begin
			status <= 16'h0000;
		end else if (ce_i) begin
			if (ser_status_reset || sw_status_clear) begin
				status <= 16'h0000;
			end
			if (status_set[0]) begin
				status[CFM_ST_POR] <= 1'b1;
			end
			if (status_set[1]) begin
				status[CFM_ST_OT] <= 1'b1;
			end
			if (status_set[2]) begin
				status[CFM_ST_TW] <= 1'b1;
			end
			if (status_set[3]) begin
				status[CFM_ST_SE] <= 1'b1;
			end
			if (status_set[4]) begin
				status[CFM_ST_ANY] <= 1'b1;
			end
		end
	end

	// Diagnostic word one latches until a fault register reset.
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || !logic_up) begin
			diag1 <= 2'h0;
		end else if (ce_i) begin
			if (ser_diag1_reset || sw_diag1_clear) begin
				diag1 <= 2'h0;
			end
			if (diag1_set[0]) begin
				diag1[CFM_D1_RLOW] <= 1'b1;
			end
			if (diag1_set[1]) begin
				diag1[CFM_D1_RHIGH] <= 1'b1;
			end
		end
	end

	// Gate permission: supply good, regulator good, overtemperature only with shutdown.
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			gate_enable_o <= 1'b0;
		end else if (ce_i) begin
			gate_enable_o <= mon.logic_ok & logic_up & ~rlow_live
				& ~(ot_live & config_q[CFM_CF_ESF]);
		end
	end

	// Serial frame shifter; status is loaded at frame start and shifted MSB first.
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || !logic_up) begin
			in_frame <= 1'b0;
			edge_cnt <= 5'h00;
			shift_in <= 16'h0000;
			shift_out <= 16'h0000;
		end else if (ce_i) begin
			if (frame_start) begin
				in_frame <= 1'b1;
				edge_cnt <= 5'h00;
				shift_out <= status;
			end else if (frame_end) begin
				in_frame <= 1'b0;
			end else if (sclk_rise && in_frame) begin
				// Saturate so a long frame still counts as too many edges.
				if (edge_cnt != 5'h1F) begin
					edge_cnt <= edge_cnt + 5'h01;
				end
				shift_in <= {shift_in[14:0], ser_sync[0]};
				shift_out <= {shift_out[14:0], 1'b0};
			end
		end
	end

	// Serial data output, low outside frames.
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			serial_dout_o <= 1'b0;
		end else if (ce_i) begin
			serial_dout_o <= in_frame & shift_out[15];
		end
	end

	// Configuration register; survives nothing past a supply loss.
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || !logic_up) begin
			config_q <= CFM_CONFIG_RST;
		end else if (ce_i && bus_wr && avs_address_i == CFM_ADDR_CONFIG) begin
			config_q <= avs_writedata_i[3:0];
		end
	end

	// Avalon slave: two wait cycles, then waitrequest low for exactly one cycle.
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			req_pending <= 1'b0;
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			if (req_pending) begin
				req_pending <= 1'b0;
				avs_waitrequest_o <= 1'b0;
				case (avs_address_i)
					CFM_ADDR_STATUS: avs_readdata_o <= {16'h0000, status};
					CFM_ADDR_DIAG1: avs_readdata_o <= {30'h0, diag1};
					CFM_ADDR_CONFIG: avs_readdata_o <= {28'h0, config_q};
					default: avs_readdata_o <= 32'h0000_0000;
				endcase
			end else begin
				avs_waitrequest_o <= 1'b1;
				req_pending <= (avs_read_i | avs_write_i) & avs_waitrequest_o;
			end
		end
	end
endmodule : cfm_top

// [cfm_sva.sv]
// Port-level assertions for the chip fault monitor.
`timescale 1ns/10ps
module cfm_sva import cfm_pkg::*; (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic logic_ok_i,
	input wire logic overtemp_i,
	input wire logic reg_low_i,
	input wire logic frame_strobe_n_i,
	input wire logic serial_dout_o,
	input wire logic gate_enable_o,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o
);
	logic [1:0] cfg;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Shadow of shutdown enable and low-rail mask; supply loss resets it as it does the config.
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || !logic_ok_i)
			cfg <= 2'h1;
		else if (avs_write_i && !avs_waitrequest_o && avs_address_i == CFM_ADDR_CONFIG)
			cfg <= avs_writedata_i[1:0];
	end
	supply_loss_a: assert property (!logic_ok_i [*4] |-> !gate_enable_o)
		else $error("gate on without logic supply");
	// Live fault states add a stage over the supply path, so these need one more sample.
	reg_low_a: assert property ((reg_low_i && !cfg[1]) [*5] |-> !gate_enable_o)
		else $error("gate on during low rail");
	overheat_off_a: assert property ((overtemp_i && cfg[0]) [*5] |-> !gate_enable_o)
		else $error("gate on during overheat shutdown");
	overheat_kept_a: assert property ((gate_enable_o && !cfg[0] && logic_ok_i
		&& !reg_low_i) [*3] |=> gate_enable_o)
		else $error("gate dropped without cause");
	gate_rise_a: assert property ($rose(gate_enable_o) |-> $past(logic_ok_i, 3)
		&& (!$past(reg_low_i, 3) || cfg[1]))
		else $error("gate rose without supply");
	wait_bound_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|-> ##[1:2] !avs_waitrequest_o)
		else $error("bus answer late");
	wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	unmapped_zero_a: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[1:0] != 2'h0
		|-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	dout_idle_a: assert property (frame_strobe_n_i [*6] |-> !serial_dout_o)
		else $error("serial out active outside frame");
endmodule : cfm_sva

// [cfm_host.sv]
// Serial controller model that frames transfers for the fault monitor.
`timescale 1ns/10ps
module cfm_host (
	input wire logic sys_clk_i,
	input wire logic sdo_i,
	output logic sclk_o,
	output logic strobe_n_o,
	output logic din_o,
	output logic [15:0] rx_o
);
	// Idle lines: clock parked low, strobe high.
	initial begin
		sclk_o = 1'h0;
		strobe_n_o = 1'h1;
		din_o = 1'h0;
		rx_o = 16'h0;
	end
	// Sends n rises of w, MSB first; eight clocks a phase outruns the two-flop sampler.
	task automatic send(input logic [15:0] w, input int n);
		strobe_n_o <= 1'h0;
		for (int i = 0; i < n; i++) begin
			din_o <= w[4'(15 - i)];
			repeat (8) @(posedge sys_clk_i);
			rx_o <= {rx_o[14:0], sdo_i};
			sclk_o <= 1'h1;
			repeat (8) @(posedge sys_clk_i);
			sclk_o <= 1'h0;
		end
		repeat (8) @(posedge sys_clk_i);
		strobe_n_o <= 1'h1;
		din_o <= ~din_o;
		repeat (8) @(posedge sys_clk_i);
	endtask : send
endmodule : cfm_host

// [cfm_top_tb.sv]
// Self-checking testbench for the chip fault monitor.
`timescale 1ns/10ps
module cfm_top_tb import cfm_pkg::*;;
	typedef struct packed {
		logic fault_shutdown_enable, ot, tw, rl, rh, gate;
		logic [15:0] st;
		logic [1:0] dg;
	} cfm_row_t;
	cfm_row_t rows [6] = '{24'h840000, 24'hC28000, 24'h468000, 24'hA64000, 24'h900001, 24'h8C0002};
	cfm_row_t r;
	logic sys_clk_i = 1'h0, reset_n_i = 1'h0, logic_ok_i = 1'h1, reg_low_i = 1'h1;
	logic overtemp_i = 1'h0, heat_warn_i = 1'h0, reg_high_i = 1'h0;
	logic avs_read_i = 1'h0, avs_write_i = 1'h0;
	logic [3:0] avs_address_i = 4'h0;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, got;
	logic avs_waitrequest_o, serial_dout_o, gate_enable_o, serial_clk_i, frame_strobe_n_i;
	logic serial_din_i;
	logic [15:0] rx;
	int mismatches = 0, n_tests = 0, cycles = 0;
	cfm_top uut (.sys_clk_i, .reset_n_i, .ce_i(1'h1), .logic_ok_i, .overtemp_i, .heat_warn_i,
		.reg_low_i, .reg_high_i, .serial_clk_i, .frame_strobe_n_i, .serial_din_i, .serial_dout_o,
		.gate_enable_o, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_readdata_o, .avs_waitrequest_o);
	cfm_host host (.sys_clk_i, .sdo_i(serial_dout_o), .sclk_o(serial_clk_i),
		.strobe_n_o(frame_strobe_n_i), .din_o(serial_din_i), .rx_o(rx));
	// 100 MHz clock and a hang guard well above the two thousand or so cycles needed.
	always #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			test_done();
		end
	end
	task automatic test_done();
		$display("tests %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Holds the request until waitrequest is sampled low, then frees the bus for a cycle.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address_i <= a;
		avs_write_i <= w;
		avs_read_i <= !w;
		avs_writedata_i <= d;
		@(posedge sys_clk_i);
		while (avs_waitrequest_o) @(posedge sys_clk_i);
		got = avs_readdata_o;
		avs_read_i <= 1'h0;
		avs_write_i <= 1'h0;
		@(posedge sys_clk_i);
	endtask : bus
	task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0);
		check(got, exp);
	endtask : rdchk
	// Main sequence: power-up, table rows, then serial and supply cases.
	initial begin
		repeat (3) @(posedge sys_clk_i);
		reset_n_i <= 1'h1;
		repeat (8) @(posedge sys_clk_i);
		check(32'(gate_enable_o), 32'h0);
		reg_low_i <= 1'h0;
		repeat (6) @(posedge sys_clk_i);
		check(32'(gate_enable_o), 32'h1);
		rdchk(CFM_ADDR_STATUS, 32'hC000);
		foreach (rows[i]) begin
			r = rows[i];
			bus(1'h1, CFM_ADDR_CONFIG, 32'(r.fault_shutdown_enable));
			bus(1'h1, CFM_ADDR_CLEAR, 32'h3);
			{overtemp_i, heat_warn_i, reg_low_i, reg_high_i} <= {r.ot, r.tw, r.rl, r.rh};
			repeat (6) @(posedge sys_clk_i);
			check(32'(gate_enable_o), 32'(r.gate));
			{overtemp_i, heat_warn_i, reg_low_i, reg_high_i} <= 4'h0;
			repeat (6) @(posedge sys_clk_i);
			check(32'(gate_enable_o), 32'h1);
			rdchk(CFM_ADDR_STATUS, 32'(r.st));
			rdchk(CFM_ADDR_DIAG1, 32'(r.dg));
		end
		// Every maskable monitor masked: no diagnostic flag and no gate action.
		bus(1'h1, CFM_ADDR_CONFIG, 32'hF);
		bus(1'h1, CFM_ADDR_CLEAR, 32'h3);
		{reg_low_i, reg_high_i, heat_warn_i} <= 3'h7;
		repeat (6) @(posedge sys_clk_i);
		check(32'(gate_enable_o), 32'h1);
		{reg_low_i, reg_high_i, heat_warn_i} <= 3'h0;
		rdchk(CFM_ADDR_DIAG1, 32'h0);
		bus(1'h1, CFM_ADDR_CONFIG, 32'h1);
		// A warning leaves a known status for the frame to shift out.
		heat_warn_i <= 1'h1;
		repeat (6) @(posedge sys_clk_i);
		heat_warn_i <= 1'h0;
		host.send(16'h1401, 16);
		check(32'(rx), 32'h9000);
		rdchk(CFM_ADDR_STATUS, 32'h0);
		for (int k = 0; k < 3; k++) begin
			bus(1'h1, CFM_ADDR_CLEAR, 32'h3);
			heat_warn_i <= 1'h1;
			repeat (6) @(posedge sys_clk_i);
			heat_warn_i <= 1'h0;
			// Too few edges, too many edges, then even parity.
			host.send(16'h1401 ^ 16'(k == 2), (k == 0) ? 15 : ((k == 1) ? 17 : 16));
			rdchk(CFM_ADDR_STATUS, 32'h9800);
		end
		reg_high_i <= 1'h1;
		repeat (6) @(posedge sys_clk_i);
		reg_high_i <= 1'h0;
		host.send(16'h0801, 16);
		rdchk(CFM_ADDR_DIAG1, 32'h2);
		host.send(16'h0800, 16);
		rdchk(CFM_ADDR_DIAG1, 32'h0);
		// All masks set: the supply lockout must still act, and the reset must drop them.
		bus(1'h1, CFM_ADDR_CONFIG, 32'hE);
		logic_ok_i <= 1'h0;
		repeat (10) @(posedge sys_clk_i);
		check(32'(gate_enable_o), 32'h0);
		logic_ok_i <= 1'h1;
		repeat (10) @(posedge sys_clk_i);
		check(32'(gate_enable_o), 32'h1);
		rdchk(CFM_ADDR_STATUS, 32'hC000);
		rdchk(CFM_ADDR_CONFIG, 32'h1);
		bus(1'h1, CFM_ADDR_STATUS, 32'h0);
		rdchk(CFM_ADDR_STATUS, 32'hC000);
		rdchk(4'h1, 32'h0);
		test_done();
	end
endmodule : cfm_top_tb
bind cfm_top cfm_sva chk (.sys_clk_i, .reset_n_i, .logic_ok_i, .overtemp_i, .reg_low_i,
	.frame_strobe_n_i, .serial_dout_o, .gate_enable_o, .avs_address_i, .avs_read_i, .avs_write_i,
	.avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o);
